/* sadc_pkg.sv */
// Package with constants, types and register map for the ADC sense sequencer.
package sadc_pkg;

  localparam int RES_W = 10;
  localparam int CH_W = 5;
  localparam int NUM_CH = 32;
  localparam logic [CH_W-1:0] AUTO_LAST_CH = 5'h0A;
  localparam logic [CH_W-1:0] EXT_CURRENT_CH = 5'h03;
  localparam int CONVERT_CYCLES = 12;
  localparam int INT_PULSE_CYCLES = 2;
  localparam int EN_TIME_RST = 4;
  localparam int SAMPLE_TIME_RST = 4;
  localparam int TIME_W = 8;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TIMING = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT_BASE = 8'h80;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_REPEAT_BIT = 3;
  localparam int CTRL_START_BIT = 4;
  localparam int CTRL_CH_LSB = 8;
  localparam int TIMING_SAMPLE_LSB = 8;

  typedef enum logic [1:0] {
    SADC_MODE_SINGLE = 2'h0,
    SADC_MODE_ROUND = 2'h1,
    SADC_MODE_ONCE = 2'h2
  } sadc_mode_t;

  typedef enum logic [4:0] {
    SADC_IDLE = 5'h01,
    SADC_ENABLE = 5'h02,
    SADC_SAMPLE = 5'h04,
    SADC_CONVERT = 5'h08,
    SADC_INTR = 5'h10
  } sadc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sadc_bus_req_t;

  typedef struct packed {
    logic start;
    logic [CH_W-1:0] channel;
  } sadc_conv_req_t;

endpackage

/* sadc_sar_engine.sv */
// Successive-approximation engine: one compare per cycle, fixed conversion length.
`timescale 1ns/1ps
`default_nettype none
module sadc_sar_engine
  import sadc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic comp_in,
  output logic [RES_W-1:0] dac_code,
  output logic done,
  output logic [RES_W-1:0] result
);

  logic [3:0] cnt_q;
  logic busy_q;
  logic [RES_W-1:0] trial_q;
  logic [RES_W-1:0] code_q;
  logic done_q;

  assign dac_code = code_q | trial_q;
  assign done = done_q;

  // The bit trials run in the first ten cycles and the result latches on the eleventh.
  // The registered done flag fills the twelfth, so the sequencer leaves conversion on time.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      trial_q <= '0;
      code_q <= '0;
      done_q <= 1'b0;
      result <= '0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start && !busy_q)
      begin
        busy_q <= 1'b1;
        cnt_q <= 4'h0;
        code_q <= '0;
        trial_q <= {1'b1, {(RES_W-1){1'b0}}};
      end
      else if (busy_q)
      begin
        cnt_q <= cnt_q + 4'h1;
        if (trial_q != '0)
        begin
          if (comp_in)
          begin
            code_q <= code_q | trial_q;
          end
          trial_q <= trial_q >> 1;
        end
        if (cnt_q == 4'(CONVERT_CYCLES - 2))
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          result <= code_q;
        end
      end
    end
  end

endmodule // sadc_sar_engine
`default_nettype wire

/* sadc_sequencer.sv */
// Digital sense sequencer that drives the SAR converter and holds per-channel results.
// Function
// - Each conversion yields an unsigned 10-bit code for the selected input.
// - The input multiplexer is addressed by channels 0 to 31.
// - Only channels 0 to 10 take part in the automatic sequence.
// - Firmware picks single, round-robin or one-time mode; the sequence follows it.
// - A single sample on one chosen channel is converted, without averaging.
// - Channel 3 converts the external path current from the sense pin difference.
// - After each conversion the result is held for firmware to read.
// - Single mode: enable time (first start after enabling only), sample time, 12-cycle conversion, 2-cycle interrupt pulse.
// - In single mode with repeat on, a new conversion starts as soon as the pulse ends.
// - Round-robin converts the sequence continuously, overwriting previous results.
// - One-time mode runs one pass, stops after channel 10, then interrupts.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sadc_sequencer
  import sadc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic comp_in,
  output logic [RES_W-1:0] dac_code,
  output logic [CH_W-1:0] mux_channel,
  output logic sample_en,
  output logic adc_enable,
  output logic conv_irq
);

  sadc_bus_req_t bus;
  logic en_q;
  sadc_mode_t mode_q;
  logic repeat_q;
  logic [CH_W-1:0] sel_ch_q;
  logic start_q;
  logic [TIME_W-1:0] en_time_q;
  logic [TIME_W-1:0] sample_time_q;
  sadc_state_t state_q;
  logic [TIME_W-1:0] tmr_q;
  logic [CH_W-1:0] cur_ch_q;
  logic eng_start;
  logic eng_done;
  logic [RES_W-1:0] eng_result;
  logic [RES_W-1:0] results_q [NUM_CH];
  logic [NUM_CH-1:0] fresh_q;
  logic pass_done_q;
  logic last_ch;
  logic was_en_q;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  function automatic logic is_result_addr(input logic [7:0] a);
    is_result_addr = (a >= REG_RESULT_BASE) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [CH_W-1:0] result_index(input logic [7:0] a);
    result_index = a[CH_W+1:2];
  endfunction

  // Control and timing registers written by firmware.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      en_q <= 1'b0;
      mode_q <= SADC_MODE_SINGLE;
      repeat_q <= 1'b0;
      sel_ch_q <= '0;
      start_q <= 1'b0;
      en_time_q <= TIME_W'(EN_TIME_RST);
      sample_time_q <= TIME_W'(SAMPLE_TIME_RST);
    end
    else
    begin
      start_q <= 1'b0;
      if (bus.wr && bus.addr == REG_CTRL)
      begin
        en_q <= bus.wdata[CTRL_EN_BIT];
        if (bus.wdata[CTRL_MODE_LSB +: 2] != 2'h3)
        begin
          mode_q <= sadc_mode_t'(bus.wdata[CTRL_MODE_LSB +: 2]);
        end
        repeat_q <= bus.wdata[CTRL_REPEAT_BIT];
        sel_ch_q <= bus.wdata[CTRL_CH_LSB +: CH_W];
        start_q <= bus.wdata[CTRL_START_BIT];
      end
      if (bus.wr && bus.addr == REG_TIMING)
      begin
        en_time_q <= bus.wdata[0 +: TIME_W];
        sample_time_q <= bus.wdata[TIMING_SAMPLE_LSB +: TIME_W];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      was_en_q <= 1'b0;
    end
    else if (state_q == SADC_IDLE || state_q == SADC_ENABLE)
    begin
      was_en_q <= en_q && (was_en_q || state_q == SADC_ENABLE);
    end
    else if (!en_q)
    begin
      was_en_q <= 1'b0;
    end
  end

  assign last_ch = (cur_ch_q == AUTO_LAST_CH);

  // Sequencing state machine.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= SADC_IDLE;
      tmr_q <= '0;
      cur_ch_q <= '0;
      pass_done_q <= 1'b0;
    end
    else if (!en_q)
    begin
      state_q <= SADC_IDLE;
      tmr_q <= '0;
    end
    else
    begin
      unique case (state_q)
        SADC_IDLE:
        begin
          if (start_q)
          begin
            pass_done_q <= 1'b0;
            cur_ch_q <= (mode_q == SADC_MODE_SINGLE) ? sel_ch_q : '0;
            tmr_q <= '0;
            state_q <= was_en_q ? SADC_SAMPLE : SADC_ENABLE;
          end
        end
        SADC_ENABLE:
        begin
          tmr_q <= tmr_q + TIME_W'(1);
          if (tmr_q + TIME_W'(1) >= en_time_q)
          begin
            tmr_q <= '0;
            state_q <= SADC_SAMPLE;
          end
        end
        SADC_SAMPLE:
        begin
          tmr_q <= tmr_q + TIME_W'(1);
          if (tmr_q + TIME_W'(1) >= sample_time_q)
          begin
            tmr_q <= '0;
            state_q <= SADC_CONVERT;
          end
        end
        SADC_CONVERT:
        begin
          if (eng_done)
          begin
            tmr_q <= '0;
            if (mode_q == SADC_MODE_SINGLE || (mode_q == SADC_MODE_ONCE && last_ch))
            begin
              pass_done_q <= mode_q == SADC_MODE_ONCE;
              state_q <= SADC_INTR;
            end
            else
            begin
              cur_ch_q <= last_ch ? '0 : cur_ch_q + 5'h01;
              state_q <= SADC_SAMPLE;
            end
          end
        end
        SADC_INTR:
        begin
          tmr_q <= tmr_q + TIME_W'(1);
          if (tmr_q == TIME_W'(INT_PULSE_CYCLES - 1))
          begin
            tmr_q <= '0;
            cur_ch_q <= sel_ch_q;
            state_q <= (mode_q == SADC_MODE_SINGLE && repeat_q) ? SADC_SAMPLE : SADC_IDLE;
          end
        end
        default:
        begin
          state_q <= SADC_IDLE;
        end
      endcase
    end
  end

  assign eng_start = (state_q == SADC_SAMPLE) && (tmr_q + TIME_W'(1) >= sample_time_q);

  // The comparator is strobed by this clock, so each trial must see its decision without synchroniser delay.
  sadc_sar_engine u_engine (
    .clock(clock),
    .rst(rst),
    .start(eng_start),
    .comp_in(comp_in),
    .dac_code(dac_code),
    .done(eng_done),
    .result(eng_result)
  );

  // Channel 3 is wired to the current-sense difference amplifier in the analog mux.
  // Results are only written by conversions; reads leave them untouched.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        results_q[i] <= '0;
      end
      fresh_q <= '0;
    end
    else
    begin
      if (state_q == SADC_CONVERT && eng_done)
      begin
        results_q[cur_ch_q] <= eng_result;
        fresh_q[cur_ch_q] <= 1'b1;
      end
      if (bus.wr && bus.addr == REG_STATUS)
      begin
        fresh_q <= '0;
        if (state_q == SADC_CONVERT && eng_done)
        begin
          fresh_q <= NUM_CH'(1) << cur_ch_q;
        end
      end
    end
  end

  // Read data stands in the cycle after the read strobe.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdata <= '0;
    end
    else if (bus.rd)
    begin
      if (bus.addr == REG_CTRL)
      begin
        rdata <= {19'h0, sel_ch_q, 4'h0, repeat_q, mode_q, en_q};
      end
      else if (bus.addr == REG_TIMING)
      begin
        rdata <= {16'h0, sample_time_q, en_time_q};
      end
      else if (bus.addr == REG_STATUS)
      begin
        rdata <= {24'h0, pass_done_q, |fresh_q, 1'b0, state_q};
      end
      else if (is_result_addr(bus.addr))
      begin
        rdata <= {22'h0, results_q[result_index(bus.addr)]};
      end
      else
      begin
        rdata <= '0;
      end
    end
    else
    begin
      rdata <= '0;
    end
  end

  assign mux_channel = cur_ch_q;
  assign sample_en = (state_q == SADC_SAMPLE);
  assign adc_enable = en_q;
  assign conv_irq = (state_q == SADC_INTR);

  logic [3:0] conv_cnt_q;

  // Counts the cycles spent converting, so that the conversion length can be checked.
  always_ff @(posedge clock)
  begin
    if (rst || state_q != SADC_CONVERT)
    begin
      conv_cnt_q <= 4'h0;
    end
    else
    begin
      conv_cnt_q <= conv_cnt_q + 4'h1;
    end
  end

  conv_len_a: assert property (@(posedge clock) disable iff (rst)
    state_q == SADC_CONVERT && eng_done |-> conv_cnt_q == 4'(CONVERT_CYCLES - 1))
    else $error("conversion not twelve cycles long");

  irq_pulse_a: assert property (@(posedge clock) disable iff (rst)
    $rose(conv_irq) && en_q |=> conv_irq ##1 !conv_irq)
    else $error("interrupt pulse not two cycles");

  repeat_go_a: assert property (@(posedge clock) disable iff (rst)
    $fell(conv_irq) && en_q && repeat_q && mode_q == SADC_MODE_SINGLE |-> state_q == SADC_SAMPLE)
    else $error("repeat did not restart sampling");

  auto_range_a: assert property (@(posedge clock) disable iff (rst)
    mode_q != SADC_MODE_SINGLE && state_q == SADC_CONVERT |-> cur_ch_q <= AUTO_LAST_CH)
    else $error("auto sequence left channels 0 to 10");

  once_stop_a: assert property (@(posedge clock) disable iff (rst)
    mode_q == SADC_MODE_ONCE && state_q == SADC_CONVERT && eng_done && last_ch && en_q
    |=> state_q == SADC_INTR ##2 state_q == SADC_IDLE)
    else $error("one-time pass did not stop");

  round_wrap_a: assert property (@(posedge clock) disable iff (rst)
    mode_q == SADC_MODE_ROUND && state_q == SADC_CONVERT && eng_done && last_ch && en_q
    |=> cur_ch_q == 5'h00 && state_q == SADC_SAMPLE)
    else $error("round robin did not wrap");

  result_store_a: assert property (@(posedge clock) disable iff (rst)
    state_q == SADC_CONVERT && eng_done |=> results_q[$past(cur_ch_q)] == $past(eng_result))
    else $error("result not stored");

  result_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(state_q == SADC_CONVERT && eng_done) |=> $stable(results_q[0]))
    else $error("result changed without conversion");

  single_ch_a: assert property (@(posedge clock) disable iff (rst)
    mode_q == SADC_MODE_SINGLE && state_q == SADC_CONVERT && eng_done && en_q |=> state_q == SADC_INTR)
    else $error("single mode converted more than one sample");

endmodule // sadc_sequencer
`default_nettype wire

/* sadc_analog_model.sv */
// Analog front end model: comparator between the selected input and the DAC trial code.
`timescale 1ns/1ps
`default_nettype none
module sadc_analog_model
  import sadc_pkg::*;
(
  input wire logic [RES_W-1:0] dac_code,
  input wire logic [CH_W-1:0] mux_channel,
  input wire logic [RES_W-1:0] bias,
  output logic comp_in
);
  // Each input sits half a code above its level, so the search must settle on the level itself.
  always_comb
  begin
    comp_in = (({mux_channel, 5'h15} ^ bias) >= dac_code);
  end
endmodule // sadc_analog_model
`default_nettype wire

/* tb_sadc_sequencer.sv */
// Self-checking testbench for the ADC sense sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_sadc_sequencer
  import sadc_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic comp_in;
  logic [RES_W-1:0] dac_code;
  logic [CH_W-1:0] mux_channel;
  logic sample_en;
  logic adc_enable;
  logic conv_irq;
  logic [RES_W-1:0] bias = 10'h000;
  logic [CH_W-1:0] max_ch = 5'h00;
  logic [31:0] d;
  int n_mismatch = 0;
  int samples_checked = 0;
  int ns, ng, ni, k;
  // Channel 12 is read the way firmware reads a config pin that carries signalling.
  logic [4:0] sc [4] = '{5'h00, 5'h03, 5'h0C, 5'h1F};
  logic [9:0] sb [4] = '{10'h015, 10'h000, 10'h000, 10'h00A};

  sadc_sequencer u_sadc_sequencer (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .comp_in(comp_in), .dac_code(dac_code), .mux_channel(mux_channel), .sample_en(sample_en),
    .adc_enable(adc_enable), .conv_irq(conv_irq));
  sadc_analog_model u_sadc_analog_model (.dac_code(dac_code), .mux_channel(mux_channel), .bias(bias),
    .comp_in(comp_in));

  always #50 clock = ~clock;

  // Highest channel sampled since the last control write, to catch a sequence that strays past its end.
  always @(posedge clock)
  begin
    if (wr === 1'b1 && addr == REG_CTRL)
      max_ch <= 5'h00;
    else if (sample_en === 1'b1 && mux_channel > max_ch)
      max_ch <= mux_channel;
  end

  // Code the model presents on a channel; firmware scales it by full scale and the divider ratio.
  function automatic logic [9:0] lvl(input logic [4:0] ch, input logic [9:0] b);
    return {ch, 5'h15} ^ b;
  endfunction

  function automatic logic [31:0] ctrl(input logic [1:0] m, input logic rep, input logic [4:0] ch);
    return {19'h0, ch, 3'h0, 1'b1, rep, m, 1'b1};
  endfunction

  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic chk_res(input logic [4:0] ch, input logic [9:0] e);
    logic [31:0] v;
    repeat (2)
    begin
      rd_reg(REG_RESULT_BASE + {1'b0, ch, 2'b00}, v);
      check(v, {22'h0, e});
    end
  endtask

  // Counts sampling cycles, conversion gap and interrupt pulse length of the next conversion.
  task automatic measure();
    ns = 0;
    ng = 0;
    ni = 0;
    k = 0;
    #1;
    while (sample_en !== 1'b1 && k < 100)
    begin
      @(posedge clock);
      #1;
      k++;
    end
    while (sample_en === 1'b1 && ns < 300)
    begin
      @(posedge clock);
      #1;
      ns++;
    end
    while (conv_irq !== 1'b1 && ng < 1000)
    begin
      @(posedge clock);
      #1;
      ng++;
    end
    while (conv_irq === 1'b1 && ni < 300)
    begin
      @(posedge clock);
      #1;
      ni++;
    end
  endtask

  initial
  begin
    repeat (10000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    check(32'(conv_irq), 32'h0);
    check(32'(adc_enable), 32'h0);
    check(32'(dac_code), 32'h0);
    rd_reg(REG_TIMING, d);
    check(d, 32'h00000404);
    rd_reg(REG_STATUS, d);
    check(d, 32'h00000001);
    rd_reg(8'h40, d);
    check(d, 32'h0);
    wr_reg(REG_TIMING, 32'h00000302);
    for (int i = 0; i < 4; i++)
    begin
      bias <= sb[i];
      wr_reg(REG_CTRL, ctrl(2'h0, 1'b0, sc[i]));
      measure();
      check(ns, 3);
      check(ng, CONVERT_CYCLES);
      check(ni, INT_PULSE_CYCLES);
      check(32'(mux_channel), 32'(sc[i]));
      chk_res(sc[i], lvl(sc[i], sb[i]));
    end
    bias <= 10'h155;
    wr_reg(REG_CTRL, ctrl(2'h0, 1'b1, 5'h07));
    measure();
    check(32'(sample_en), 32'h1);
    bias <= 10'h0AA;
    measure();
    check(ns, 3);
    check(ni, INT_PULSE_CYCLES);
    chk_res(5'h07, lvl(5'h07, 10'h0AA));
    wr_reg(REG_CTRL, 32'h0);
    repeat (3) @(posedge clock);
    rd_reg(REG_STATUS, d);
    check(d[7:0], 8'h41);
    wr_reg(REG_STATUS, 32'h0);
    rd_reg(REG_STATUS, d);
    check(d[7:0], 8'h01);
    wr_reg(REG_CTRL, 32'h00000006);
    rd_reg(REG_CTRL, d);
    check(d, 32'h0);
    check(32'(adc_enable), 32'h0);
    bias <= 10'h2C3;
    wr_reg(REG_CTRL, ctrl(2'h2, 1'b0, 5'h00));
    measure();
    check(ni, INT_PULSE_CYCLES);
    check(32'(max_ch), 32'(AUTO_LAST_CH));
    repeat (20) @(posedge clock);
    rd_reg(REG_STATUS, d);
    check(d[7:0], 8'hC1);
    for (int c = 0; c <= 10; c++)
      chk_res(5'(c), lvl(5'(c), 10'h2C3));
    chk_res(5'h0C, lvl(5'h0C, 10'h000));
    bias <= 10'h0F0;
    wr_reg(REG_CTRL, ctrl(2'h1, 1'b0, 5'h00));
    k = 0;
    repeat (600)
    begin
      @(negedge clock);
      if (conv_irq !== 1'b0)
        k++;
    end
    check(k, 0);
    bias <= 10'h30F;
    repeat (600) @(posedge clock);
    for (int c = 0; c <= 10; c++)
      chk_res(5'(c), lvl(5'(c), 10'h30F));
    check(32'(max_ch), 32'(AUTO_LAST_CH));
    chk_res(5'h1F, lvl(5'h1F, 10'h00A));
    wr_reg(REG_CTRL, 32'h0);
    end_of_test();
  end
endmodule // tb_sadc_sequencer
`default_nettype wire
